//--- logic/eamc_pkg.sv
// Constants shared by the energy accumulation mode control block.
// Assumes a 16-bit register address space and 32-bit register data.
package eamc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CFG_W = 8;
  localparam int NUM_PHASE = 3;
  localparam int NUM_KIND = 5;
  localparam int NUM_CH = NUM_PHASE * NUM_KIND;
  localparam int LC_CNT_W = 16;
  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_LINE_CYCLE_MODE_CONFIG = 16'hE702;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CYCLE_COUNT = 16'hE7F0;
  localparam logic [ADDR_W-1:0] ADDR_ACC_BASE = 16'hE400;
  // Field positions of the configuration register.
  localparam int BIT_ACTIVE_LC = 0;
  localparam int BIT_REACTIVE_LC = 1;
  localparam int BIT_APPARENT_LC = 2;
  localparam int BIT_ZX_LO = 3;
  localparam int BIT_ZX_HI = 5;
  localparam int BIT_CLEAR_ON_READ = 6;
  localparam int BIT_RESERVED = 7;
  // Reset values and write masks.
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h78;
  localparam logic [CFG_W-1:0] CFG_WRITE_MASK = 8'h7F;
  localparam logic [CFG_W-1:0] CFG_NO_REACTIVE_MASK = 8'h7D;
  localparam logic [LC_CNT_W-1:0] LC_COUNT_RESET = 16'h0064;
  // Accumulator kinds within one phase; channel = phase * NUM_KIND + kind.
  localparam int KIND_ACTIVE = 0;
  localparam int KIND_FUND_ACTIVE = 1;
  localparam int KIND_REACTIVE = 2;
  localparam int KIND_FUND_REACTIVE = 3;
  localparam int KIND_APPARENT = 4;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage : eamc_pkg

//--- logic/eamc_accum.sv
// One energy accumulator with regular and line-cycle modes and clear on read.
// Assumes cycle_done is a one-cycle pulse from the shared zero-crossing counter.
`timescale 1ns/1ps
module eamc_accum
  import eamc_pkg::*;
#(
  parameter int PWR_W = 24,
  parameter int ACC_W = 32
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic sample_valid, // Power sample strobe.
  input wire logic [PWR_W-1:0] sample_in, // Signed power sample.
  input wire logic line_mode, // High selects line-cycle accumulation.
  input wire logic cycle_done, // End of a line-cycle period.
  input wire logic clear_req, // Read with clear of this accumulator.
  output logic [ACC_W-1:0] energy_out // Register content seen by software.
);

  logic [ACC_W-1:0] energy_reg;
  logic [ACC_W-1:0] energy_next;
  logic [ACC_W-1:0] shadow_reg;
  logic [ACC_W-1:0] shadow_next;
  logic [ACC_W-1:0] sample_ext;
  logic [ACC_W-1:0] energy_base;
  logic [ACC_W-1:0] shadow_sum;

  assign sample_ext = sample_valid ? {{(ACC_W-PWR_W){sample_in[PWR_W-1]}}, sample_in} : '0;
  // A clear and a new sample in the same cycle keep the sample.
  assign energy_base = clear_req ? '0 : energy_reg; // [R7] [R8]
  assign shadow_sum = ACC_W'(shadow_reg + sample_ext);
  assign energy_next = !line_mode ? ACC_W'(energy_base + sample_ext) :
                       cycle_done ? shadow_sum : energy_base; // [R11]
  assign shadow_next = (!line_mode || cycle_done) ? '0 : shadow_sum;
  assign energy_out = energy_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      energy_reg <= '0;
      shadow_reg <= '0;
    end else begin
      energy_reg <= energy_next;
      shadow_reg <= shadow_next;
    end
  end

  property p_lc_update;
    @(posedge clk_sys) disable iff (!rst_n)
      (line_mode && cycle_done) |=> (energy_reg == $past(shadow_sum));
  endproperty
  a_lc_update: assert property (p_lc_update) else $error("line-cycle result not loaded"); // [R11]

endmodule : eamc_accum

//--- logic/eamc_core.sv
// Overview of operation
// R1: Bit 0 puts all active and fundamental active accumulators in line-cycle mode; resets 0.
// R2: Bit 1 puts the three reactive accumulators in line-cycle mode; resets 0.
// R3: Without reactive measurement, bit 1 stays fixed at 0.
// R4: Bit 2 puts the three apparent accumulators in line-cycle mode; resets 0.
// R5: Bits 3 to 5 select phases A, B, C as zero-crossing sources; reset 1.
// R6: Crossings of every selected phase are counted, shortening the period.
// R7: With bit 6 set (reset value) reading an energy accumulator clears it.
// R8: With bit 6 clear, reading an accumulator leaves it unchanged.
// R9: Software clears bit 6 before using line-cycle mode.
// R10: Bit 7 is reserved, has no effect and resets to 0.
// R11: Line-cycle accumulators load their result every programmed count of crossings.
//
// Energy accumulator bank with its line-cycle mode configuration register.
// Assumes synchronous power samples, zero-crossing pulses and a single-cycle register port.
`timescale 1ns/1ps
module eamc_core
  import eamc_pkg::*;
#(
  parameter int PWR_W = 24,
  parameter bit HAS_REACTIVE = 1'b1
) (
  input wire logic clk_sys, // System clock, 40 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] reg_addr, // Register address.
  input wire logic [DATA_W-1:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [DATA_W-1:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  input wire logic sample_valid, // Power samples valid.
  input wire logic [NUM_CH*PWR_W-1:0] power_in, // Power per channel, phase-major.
  input wire logic [NUM_PHASE-1:0] zero_cross_in, // Zero-crossing pulses of phases A, B, C.
  output logic line_cycle_done // End of a line-cycle period.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Returns the line-cycle selection bit that a kind of accumulator follows, or 0 for a kind that follows none.
  function automatic logic kind_line_mode(input int kind, input logic [CFG_W-1:0] cfg);
    logic sel;
    sel = 1'b0;
    case (kind)
      KIND_ACTIVE: sel = cfg[BIT_ACTIVE_LC];
      KIND_FUND_ACTIVE: sel = cfg[BIT_ACTIVE_LC];
      KIND_REACTIVE: sel = cfg[BIT_REACTIVE_LC];
      KIND_APPARENT: sel = cfg[BIT_APPARENT_LC];
      default: sel = 1'b0;
    endcase
    return sel;
  endfunction : kind_line_mode

  // Counts the crossings seen in one cycle.
  function automatic logic [1:0] crossings(input logic [NUM_PHASE-1:0] zx);
    logic [1:0] n;
    n = '0;
    for (int i = 0; i < NUM_PHASE; i++) begin
      n = 2'(n + zx[i]);
    end
    return n;
  endfunction : crossings

  ////////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  logic [CFG_W-1:0] line_cycle_mode_config_reg;
  logic [CFG_W-1:0] line_cycle_mode_config_next;
  logic [LC_CNT_W-1:0] line_cycle_count_reg;
  logic [LC_CNT_W-1:0] line_cycle_count_next;
  logic [DATA_W-1:0] reg_rdata_reg;
  logic [DATA_W-1:0] reg_rdata_next;
  logic cfg_hit;
  logic cnt_hit;
  logic acc_hit;
  logic [ADDR_W-1:0] acc_offset;
  logic [DATA_W-1:0] energy_w [NUM_CH];
  logic [NUM_CH-1:0] clear_w;
  logic [CFG_W-1:0] cfg_mask;
  logic clear_on_read_enable;
  logic [NUM_PHASE-1:0] zero_cross_phase_select;
  logic active_line_cycle_select;
  logic reactive_line_cycle_select;
  logic apparent_line_cycle_select;

  assign cfg_hit = (reg_addr == ADDR_LINE_CYCLE_MODE_CONFIG);
  assign cnt_hit = (reg_addr == ADDR_LINE_CYCLE_COUNT);
  assign acc_offset = ADDR_W'(reg_addr - ADDR_ACC_BASE);
  assign acc_hit = (reg_addr >= ADDR_ACC_BASE) && (acc_offset < ADDR_W'(NUM_CH));

  // The reserved bit is never stored, and the reactive bit is absent without reactive metering.
  assign cfg_mask = HAS_REACTIVE ? CFG_WRITE_MASK : CFG_NO_REACTIVE_MASK; // [R3] [R10]
  assign line_cycle_mode_config_next = (reg_wr && cfg_hit) ?
                                       (reg_wdata[CFG_W-1:0] & cfg_mask) : line_cycle_mode_config_reg;
  assign line_cycle_count_next = (reg_wr && cnt_hit) ? reg_wdata[LC_CNT_W-1:0] : line_cycle_count_reg;

  assign active_line_cycle_select = line_cycle_mode_config_reg[BIT_ACTIVE_LC];
  assign reactive_line_cycle_select = line_cycle_mode_config_reg[BIT_REACTIVE_LC];
  assign apparent_line_cycle_select = line_cycle_mode_config_reg[BIT_APPARENT_LC];
  assign zero_cross_phase_select = line_cycle_mode_config_reg[BIT_ZX_HI:BIT_ZX_LO];
  assign clear_on_read_enable = line_cycle_mode_config_reg[BIT_CLEAR_ON_READ];

  // Read data mux; unmapped addresses read as zero.
  always_comb begin
    reg_rdata_next = DATA_ZERO;
    if (reg_rd) begin
      if (cfg_hit) begin
        reg_rdata_next = DATA_W'(line_cycle_mode_config_reg);
      end else if (cnt_hit) begin
        reg_rdata_next = DATA_W'(line_cycle_count_reg);
      end else if (acc_hit) begin
        reg_rdata_next = energy_w[acc_offset[3:0]];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      line_cycle_mode_config_reg <= CFG_RESET; // [R1] [R2] [R4] [R5] [R7] [R10]
      line_cycle_count_reg <= LC_COUNT_RESET;
      reg_rdata_reg <= DATA_ZERO;
    end else begin
      line_cycle_mode_config_reg <= line_cycle_mode_config_next;
      line_cycle_count_reg <= line_cycle_count_next;
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Zero-crossing counter for line-cycle periods.

  logic [LC_CNT_W-1:0] zx_count_reg;
  logic [LC_CNT_W-1:0] zx_count_next;
  logic [LC_CNT_W:0] zx_sum;
  logic [1:0] zx_inc;
  logic lc_done;

  assign zx_inc = crossings(zero_cross_in & zero_cross_phase_select); // [R5] [R6]
  assign zx_sum = (LC_CNT_W+1)'(zx_count_reg) + (LC_CNT_W+1)'(zx_inc);
  // A count of zero stops the line-cycle period.
  assign lc_done = (line_cycle_count_reg != '0) &&
                   (zx_sum >= (LC_CNT_W+1)'(line_cycle_count_reg)); // [R11]
  assign zx_count_next = lc_done ? '0 : zx_sum[LC_CNT_W-1:0];
  assign line_cycle_done = lc_done;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      zx_count_reg <= '0;
    end else begin
      zx_count_reg <= zx_count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Accumulator channels.

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic ch_mode;
      assign ch_mode = kind_line_mode(g % NUM_KIND, line_cycle_mode_config_reg); // [R1] [R2] [R4]
      assign clear_w[g] = reg_rd && acc_hit && (acc_offset == ADDR_W'(g)) && clear_on_read_enable; // [R7] [R8]
      eamc_accum #(
        .PWR_W(PWR_W),
        .ACC_W(DATA_W)
      ) u_accum (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample_in(power_in[g*PWR_W +: PWR_W]),
        .line_mode(ch_mode),
        .cycle_done(lc_done),
        .clear_req(clear_w[g]),
        .energy_out(energy_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  localparam int CH_A_ACTIVE = KIND_ACTIVE;
  localparam int CH_A_REACTIVE = KIND_REACTIVE;
  localparam int CH_A_APPARENT = KIND_APPARENT;

  sequence s_quiet(int ch);
    !lc_done && !clear_w[ch];
  endsequence

  property p_active_lc_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (active_line_cycle_select and s_quiet(CH_A_ACTIVE)) |=>
        (energy_w[CH_A_ACTIVE] == $past(energy_w[CH_A_ACTIVE]));
  endproperty
  a_active_lc_hold: assert property (p_active_lc_hold) else $error("active energy moved inside a period"); // [R1]

  property p_reactive_lc_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (reactive_line_cycle_select and s_quiet(CH_A_REACTIVE)) |=>
        (energy_w[CH_A_REACTIVE] == $past(energy_w[CH_A_REACTIVE]));
  endproperty
  a_reactive_lc_hold: assert property (p_reactive_lc_hold) else $error("reactive energy moved inside a period"); // [R2]

  property p_apparent_lc_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (apparent_line_cycle_select and s_quiet(CH_A_APPARENT)) |=>
        (energy_w[CH_A_APPARENT] == $past(energy_w[CH_A_APPARENT]));
  endproperty
  a_apparent_lc_hold: assert property (p_apparent_lc_hold) else $error("apparent energy moved inside a period"); // [R4]

  property p_no_reactive;
    @(posedge clk_sys) disable iff (!rst_n)
      !HAS_REACTIVE |-> !reactive_line_cycle_select;
  endproperty
  a_no_reactive: assert property (p_no_reactive) else $error("reactive line-cycle bit set without reactive"); // [R3]

  property p_cfg_reset;
    @(posedge clk_sys) $rose(rst_n) |-> (line_cycle_mode_config_reg == CFG_RESET);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("configuration reset value wrong"); // [R5]

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && cfg_hit) |=> !line_cycle_mode_config_reg[BIT_RESERVED];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored"); // [R10]

  property p_all_phases;
    @(posedge clk_sys) disable iff (!rst_n)
      ((&(zero_cross_in & zero_cross_phase_select)) && !lc_done) |=>
        (zx_count_reg == $past(zx_count_reg) + LC_CNT_W'(NUM_PHASE));
  endproperty
  a_all_phases: assert property (p_all_phases) else $error("selected crossings not all counted"); // [R6]

  sequence s_read_a_active;
    reg_rd && (reg_addr == ADDR_ACC_BASE);
  endsequence

  property p_read_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      (s_read_a_active and (clear_on_read_enable && !sample_valid && !active_line_cycle_select)) |=>
        (energy_w[CH_A_ACTIVE] == DATA_ZERO) && (reg_rdata == $past(energy_w[CH_A_ACTIVE]));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not return and clear"); // [R7]

  property p_read_keeps;
    @(posedge clk_sys) disable iff (!rst_n)
      (s_read_a_active and (!clear_on_read_enable && !sample_valid && !active_line_cycle_select)) |=>
        (energy_w[CH_A_ACTIVE] == $past(energy_w[CH_A_ACTIVE]));
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read changed accumulator"); // [R8]

  property p_period_restart;
    @(posedge clk_sys) disable iff (!rst_n)
      lc_done |=> (zx_count_reg == '0);
  endproperty
  a_period_restart: assert property (p_period_restart) else $error("crossing count not restarted"); // [R11]

  ////////////////////////////////////////////////////////////////////////////////
  // Register port assertions.

  sequence s_cfg_write;
    reg_wr && cfg_hit;
  endsequence

  sequence s_cnt_write;
    reg_wr && cnt_hit;
  endsequence

  property p_cfg_zx_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_cfg_write |=> (zero_cross_phase_select == $past(reg_wdata[BIT_ZX_HI:BIT_ZX_LO]));
  endproperty
  a_cfg_zx_write: assert property (p_cfg_zx_write) else $error("zero-crossing selection not stored"); // [R5]

  property p_cfg_clear_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_cfg_write |=> (clear_on_read_enable == $past(reg_wdata[BIT_CLEAR_ON_READ]));
  endproperty
  a_cfg_clear_write: assert property (p_cfg_clear_write) else $error("clear-on-read bit not stored"); // [R7] [R8]

  property p_cnt_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_cnt_write |=> (line_cycle_count_reg == $past(reg_wdata[LC_CNT_W-1:0]));
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("crossing count not stored"); // [R11]

  // Read data must fall back to zero so that a stale word is never mistaken for an answer.
  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !reg_rd |=> (reg_rdata == DATA_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data shown without a read");

  // Crossings of deselected phases must leave the period count alone.
  property p_unselected_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
      (((zero_cross_in & zero_cross_phase_select) == '0) && !lc_done) |=>
        (zx_count_reg == $past(zx_count_reg));
  endproperty
  a_unselected_ignored: assert property (p_unselected_ignored) else $error("deselected crossing counted"); // [R5]

endmodule : eamc_core

//--- tb/energy_accum_mode_control_test.sv
// Self-checking bench for the energy accumulation mode control core.
// Assumes the core and its package from logic/; the bench drives every port directly.
`timescale 1ns/1ps
module energy_accum_mode_control_test;
  import eamc_pkg::*;
  localparam int PWR_W = 24;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sample_valid = 1'b0;
  logic [NUM_CH*PWR_W-1:0] power_in = '0;
  logic [NUM_PHASE-1:0] zero_cross_in = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rdata_nr;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] rd_nr_val;
  logic line_cycle_done;
  int fail_count = 0;
  int samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  eamc_core #(.PWR_W(PWR_W), .HAS_REACTIVE(1'b1)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .power_in(power_in), .zero_cross_in(zero_cross_in),
    .line_cycle_done(line_cycle_done));
  // Variant without reactive measurement shares the bus; only its read data is watched.
  eamc_core #(.PWR_W(PWR_W), .HAS_REACTIVE(1'b0)) u_norx (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_nr),
    .sample_valid(sample_valid), .power_in(power_in), .zero_cross_in(zero_cross_in), .line_cycle_done());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    rd_nr_val = rdata_nr;
  endtask : rd
  task automatic rdchk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd(a);
    chk(name, exp, rd_val);
  endtask : rdchk
  // Holds one channel's power for n sampling edges, all other channels at zero.
  task automatic samp(input int ch, input logic [PWR_W-1:0] v, input int n);
    logic [NUM_CH*PWR_W-1:0] p;
    p = '0;
    p[ch*PWR_W +: PWR_W] = v;
    @(posedge clk_sys);
    power_in <= p;
    sample_valid <= 1'b1;
    repeat (n) @(posedge clk_sys);
    sample_valid <= 1'b0;
  endtask : samp
  // One-cycle crossing pulse; the period end is judged while the pulse is present.
  task automatic zx(input logic [NUM_PHASE-1:0] z, input logic exp_done);
    @(posedge clk_sys);
    zero_cross_in <= z;
    #1;
    chk("line_cycle_done", {31'h0, exp_done}, {31'h0, line_cycle_done});
    @(posedge clk_sys);
    zero_cross_in <= '0;
  endtask : zx
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk("config", ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_0078);
    rdchk("count", ADDR_LINE_CYCLE_COUNT, 32'h0000_0064);
    rdchk("unmapped", 16'h0000, 32'h0000_0000);
  endtask : t_reset
  task automatic t_config;
    wr(ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_00FF);
    rd(ADDR_LINE_CYCLE_MODE_CONFIG);
    chk("config", 32'h0000_007F, rd_val);
    chk("config_no_reactive", 32'h0000_007D, rd_nr_val);
    wr(16'h0001, 32'h0000_0000);
    rdchk("config", ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_007F);
    wr(ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_0078);
  endtask : t_config
  task automatic t_clear;
    samp(0, 24'h000010, 3);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'h0000_0030);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'h0000_0000);
    samp(0, 24'hFFFFFF, 1);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'hFFFF_FFFF);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'h0000_0000);
    wr(ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_0038);
    samp(5, 24'h000020, 2);
    rdchk("acc_b_active", ADDR_ACC_BASE + 16'h0005, 32'h0000_0040);
    rdchk("acc_b_active", ADDR_ACC_BASE + 16'h0005, 32'h0000_0040);
  endtask : t_clear
  task automatic t_line;
    wr(ADDR_LINE_CYCLE_COUNT, 32'h0000_0002);
    wr(ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_0039);
    samp(0, 24'h000010, 4);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'h0000_0000);
    zx(3'b001, 1'b0);
    zx(3'b010, 1'b1);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'h0000_0040);
  endtask : t_line
  task automatic t_select;
    wr(ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_0009);
    zx(3'b110, 1'b0);
    zx(3'b001, 1'b0);
    zx(3'b001, 1'b1);
  endtask : t_select
  task automatic t_kinds;
    wr(ADDR_LINE_CYCLE_MODE_CONFIG, 32'h0000_003E);
    samp(2, 24'h000008, 2);
    samp(4, 24'h000003, 1);
    samp(0, 24'h000005, 1);
    rdchk("acc_a_reactive", ADDR_ACC_BASE + 16'h0002, 32'h0000_0000);
    rdchk("acc_a_apparent", ADDR_ACC_BASE + 16'h0004, 32'h0000_0000);
    rdchk("acc_a_active", ADDR_ACC_BASE, 32'h0000_0005);
    zx(3'b011, 1'b1);
    rdchk("acc_a_reactive", ADDR_ACC_BASE + 16'h0002, 32'h0000_0010);
    rdchk("acc_a_apparent", ADDR_ACC_BASE + 16'h0004, 32'h0000_0003);
    wr(ADDR_LINE_CYCLE_COUNT, 32'h0000_0005);
    zx(3'b111, 1'b0);
    zx(3'b111, 1'b1);
    rdchk("acc_a_reactive", ADDR_ACC_BASE + 16'h0002, 32'h0000_0000);
  endtask : t_kinds
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_config();
    t_clear();
    t_line();
    t_select();
    t_kinds();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end
endmodule : energy_accum_mode_control_test
